// >>> src/latency_table_pkg.sv
package latency_table_pkg;

  localparam int unsigned TABLE_BYTES = 88;
  localparam logic [6:0]  OFS_ID      = 7'h00;
  localparam logic [6:0]  OFS_LEN     = 7'h01;
  localparam logic [6:0]  OFS_LAST    = 7'h57;
  localparam logic [7:0]  PARAM_ID    = 8'h90;
  localparam logic [7:0]  PARAM_LEN   = 8'h56;
  localparam logic [7:0]  UNSUPPORTED = 8'hff;
  localparam logic [7:0]  RST_DATA    = 8'h00;
  localparam logic [1:0]  SYNC_RST    = 2'b00;

  // Query request from the serial query engine, same clock
  typedef struct packed {
    logic       valid;
    logic [6:0] offset;
  } query_req_s;

  // Byte answer returned one cycle after the request
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } query_rsp_s;

endpackage : latency_table_pkg

// >>> src/latency_table_rom.sv
`timescale 1ns/10ps
module latency_table_rom
  import latency_table_pkg::*;
(
  input  wire logic [6:0] offset,
  output logic      [7:0] data
);

  // ---------------------------------------------------------------
  // Constant contents
  // ---------------------------------------------------------------
  // No write path exists; contents are fixed in logic.
  always_comb begin
    case (offset)
      7'h00: data = PARAM_ID;
      7'h01: data = PARAM_LEN;
      7'h02: data = 8'h06;
      7'h03: data = 8'h0e;
      7'h04: data = 8'h46;
      7'h05: data = 8'h43;
      7'h06: data = 8'h03;
      7'h07: data = 8'h13;
      7'h08: data = 8'h0b;
      7'h09: data = 8'h0c;
      7'h0a: data = 8'h3b;
      7'h0b: data = 8'h3c;
      7'h0c: data = 8'h6b;
      7'h0d: data = 8'h6c;
      7'h0e: data = 8'hbb;
      7'h0f: data = 8'hbc;
      7'h10: data = 8'heb;
      7'h11: data = 8'hec;
      7'h12: data = 8'h32;
      7'h13: data = 8'h03;
      7'h14, 7'h15, 7'h16, 7'h17,
      7'h18, 7'h19, 7'h1a, 7'h1b: data = 8'h00;
      7'h1c: data = 8'h04;
      7'h1d: data = 8'h00;
      7'h1e: data = 8'h02;
      7'h1f: data = 8'h01;
      7'h20: data = 8'h50;
      7'h21: data = 8'h00;
      7'h22, 7'h23: data = UNSUPPORTED;
      7'h24: data = 8'h00;
      7'h25: data = 8'h08;
      7'h26: data = 8'h00;
      7'h27: data = 8'h08;
      7'h28: data = 8'h00;
      7'h29: data = 8'h08;
      7'h2a: data = 8'h04;
      7'h2b: data = 8'h00;
      7'h2c: data = 8'h02;
      7'h2d: data = 8'h04;
      7'h2e: data = 8'h5a;
      7'h2f: data = 8'h01;
      7'h30, 7'h31: data = UNSUPPORTED;
      7'h32: data = 8'h00;
      7'h33: data = 8'h08;
      7'h34: data = 8'h00;
      7'h35: data = 8'h08;
      7'h36: data = 8'h00;
      7'h37: data = 8'h08;
      7'h38: data = 8'h04;
      7'h39: data = 8'h01;
      7'h3a: data = 8'h02;
      7'h3b: data = 8'h04;
      7'h3c: data = 8'h68;
      7'h3d: data = 8'h02;
      7'h3e, 7'h3f: data = UNSUPPORTED;
      7'h40: data = 8'h00;
      7'h41: data = 8'h08;
      7'h42: data = 8'h00;
      7'h43: data = 8'h08;
      7'h44: data = 8'h00;
      7'h45: data = 8'h08;
      7'h46: data = 8'h04;
      7'h47: data = 8'h02;
      7'h48: data = 8'h02;
      7'h49: data = 8'h05;
      7'h4a: data = 8'h85;
      7'h4b: data = 8'h02;
      7'h4c, 7'h4d: data = UNSUPPORTED;
      7'h4e: data = 8'h00;
      7'h4f: data = 8'h08;
      7'h50, 7'h51, 7'h52, 7'h53,
      7'h54, 7'h55, 7'h56, 7'h57: data = UNSUPPORTED;
      default: data = UNSUPPORTED;
    endcase
  end

endmodule : latency_table_rom

// >>> src/enhanced_latency_code_table.sv
// Behaviour
// - Byte 00h returns 90h, identifying the single-rate latency table.
// - Byte 01h returns 56h; host finds next parameter at 01h+56h+1.
// - Header row starts with ASCII 46h then 43h column labels.
// - Header lists read codes 03h, 13h and fast codes 0Bh, 0Ch.
// - Header lists dual-out 3Bh, 3Ch and quad-out 6Bh, 6Ch.
// - Header lists dual-io BBh, BCh and quad-io EBh, ECh.
// - Second row: limit 32h (50 MHz), latency code 03h.
// - At code 11b plain, fast, dual and quad out use no cycles.
// - At code 11b dual-io read uses four mode, zero dummy.
// - At code 11b quad-io read uses two mode, one dummy.
// - Third row: limit 50h (80 MHz), latency code 00b.
// - FFh marks unsupported; plain read unsupported at 80 MHz band.
// - At code 00b fast and dual-out use eight dummy cycles.
// - At code 00b quad-out also uses eight dummy cycles.
`timescale 1ns/10ps
module enhanced_latency_code_table
  import latency_table_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       rst_b,
  input  wire query_req_s req,
  output query_rsp_s      rsp,
  output logic            out_of_range_q
);

  // ---------------------------------------------------------------
  // Lookup
  // ---------------------------------------------------------------
  logic [7:0] rom_data;
  logic       in_range;

  latency_table_rom u_rom (
    .offset (req.offset),
    .data   (rom_data)
  );

  function automatic logic offset_valid(input logic [6:0] ofs);
    return ofs <= OFS_LAST;
  endfunction : offset_valid

  assign in_range = offset_valid(req.offset);

  // ---------------------------------------------------------------
  // Registered answer
  // ---------------------------------------------------------------
  // registered read
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      rsp.valid <= 1'b0;
      rsp.data  <= RST_DATA;
    end else begin
      rsp.valid <= req.valid;
      if (req.valid) begin
        rsp.data <= rom_data;
      end
    end
  end

  // Flags a read past the last byte; data then reads FFh
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      out_of_range_q <= 1'b0;
    end else begin
      out_of_range_q <= req.valid && !in_range;
    end
  end

endmodule : enhanced_latency_code_table

// >>> verification/latency_table_checker.sv
`timescale 1ns/10ps
module latency_table_checker
  import latency_table_pkg::*;
(
  input wire logic       ref_clk,
  input wire logic       rst_b,
  input wire query_req_s req,
  input wire query_rsp_s rsp,
  input wire logic       out_of_range_q
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  wire logic t = req.valid;
  wire logic [6:0] o = req.offset;
  a_rsp_after_req: assert property (t |=> rsp.valid)
    else $error("no answer");
  // Reset itself clears the held byte, so an idle cycle in reset is exempt
  a_rsp_held: assert property (
    !t && rst_b |=> !rsp.valid && $stable(rsp.data))
    else $error("spurious answer");
  a_id_byte: assert property (
    t && o == OFS_ID |=> rsp.data == PARAM_ID)
    else $error("bad id");
  a_len_byte: assert property (
    t && o == OFS_LEN |=> rsp.data == PARAM_LEN)
    else $error("bad length");
  a_hdr_label: assert property (
    t && o == 7'h05 |=> rsp.data == 8'h43)
    else $error("bad label");
  a_row2_code: assert property (
    t && o == 7'h13 |=> rsp.data == 8'h03)
    else $error("bad code");
  a_dual_mode: assert property (
    t && o == 7'h1c |=> rsp.data == 8'h04)
    else $error("bad dual mode");
  a_row3_limit: assert property (
    t && o == 7'h20 |=> rsp.data == 8'h50)
    else $error("bad limit");
  a_read_unsup: assert property (
    t && o == 7'h22 |=> rsp.data == 8'hff)
    else $error("bad marker");
  a_quad_dummy: assert property (
    t && o == 7'h29 |=> rsp.data == 8'h08)
    else $error("bad quad dummy");
  a_range_flag: assert property (
    t |=> out_of_range_q == ($past(o) > OFS_LAST))
    else $error("bad flag");
endmodule : latency_table_checker
bind enhanced_latency_code_table latency_table_checker chk (
  .ref_clk(ref_clk), .rst_b(rst_b), .req(req), .rsp(rsp),
  .out_of_range_q(out_of_range_q));

// >>> verification/query_host.sv
`timescale 1ns/10ps
module query_host
  import latency_table_pkg::*;
(
  input wire logic ref_clk,
  output query_req_s req
);
  initial req = '0;
  task send(input logic [6:0] ofs);
    @(posedge ref_clk);
    req <= '{valid: 1'b1, offset: ofs};
  endtask : send
  // Released offset toggles so no stale value lingers
  task idle;
    @(posedge ref_clk);
    req <= '{valid: 1'b0, offset: ~req.offset};
  endtask : idle
endmodule : query_host

// >>> verification/testbench.sv
`timescale 1ns/10ps
module testbench;
  import latency_table_pkg::*;
  logic       ref_clk = 1'b0;
  logic       rst_b = 1'b0;
  query_req_s req;
  query_rsp_s rsp;
  logic       oor;
  int         num_errors = 0;
  int         checks_done = 0;
  localparam logic [335:0] TBL = {144'h9056060e4643_03130b0c3b3c6b6cbbbcebec,
    112'h3203_0000000000000000_0400_0201,
    80'h5000ffff000800080008};
  always #20 ref_clk = ~ref_clk;
  query_host host (.ref_clk(ref_clk), .req(req));
  enhanced_latency_code_table dut (.ref_clk(ref_clk), .rst_b(rst_b),
    .req(req), .rsp(rsp), .out_of_range_q(oor));
  task check(input logic [9:0] exp);
    checks_done++;
    if ({rsp.valid, oor, rsp.data} !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time,
               {rsp.valid, oor, rsp.data}, exp);
    end
  endtask : check
  // Back to back reads of every byte in the window
  task scan_table;
    for (int i = 0; i <= 42; i++) begin
      if (i < 42) host.send(i[6:0]);
      else host.idle();
      #1;
      if (i > 0) check({2'b10, TBL[8*(42-i)+:8]});
    end
  endtask : scan_table
  task range_and_hold;
    host.send(OFS_LAST);
    host.send(7'h58);
    #1 check({2'b10, UNSUPPORTED});
    host.idle();
    #1 check({2'b11, UNSUPPORTED});
    host.idle();
    #1 check({2'b00, UNSUPPORTED});
  endtask : range_and_hold
  // Reset in mid-run clears the held byte; first read follows release
  task reset_midrun;
    host.send(OFS_ID);
    host.idle();
    rst_b <= 1'b0;
    #1 check({2'b10, PARAM_ID});
    @(posedge ref_clk) rst_b <= 1'b1;
    #1 check(10'h000);
    host.send(OFS_LEN);
    host.idle();
    #1 check({2'b10, PARAM_LEN});
  endtask : reset_midrun
  task print_verdict;
    $display("errors=%0d checks=%0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (20) @(posedge ref_clk);
    rst_b <= 1'b1;
    #1 check(10'h000);
    scan_table();
    range_and_hold();
    reset_midrun();
    print_verdict();
  end
endmodule : testbench
